// File: hdl/rsf_consts.svh
`ifndef RSF_CONSTS_SVH
`define RSF_CONSTS_SVH

// Register byte offsets on the APB port.
`define RSF_OFF_CTRL        12'h000
`define RSF_OFF_BAUD_DIV    12'h004
`define RSF_OFF_SLAVE_ADDR  12'h008
`define RSF_OFF_STATUS      12'h00C
`define RSF_OFF_RX_INFO     12'h010
`define RSF_OFF_TX_CTRL     12'h014
`define RSF_OFF_EXC_CODE    12'h018
// Buffer windows, selected by paddr[11:10]; byte i sits at base + 4*i.
`define RSF_WIN_RX          2'h1
`define RSF_WIN_TX          2'h2

// Field positions.
`define RSF_CTRL_EN_BIT     0
`define RSF_CTRL_PAR_LSB    1
`define RSF_ST_RX_READY     0
`define RSF_ST_INCOMPLETE   1
`define RSF_ST_CRC_ERR      2
`define RSF_ST_CHAR_ERR     3
`define RSF_ST_TX_BUSY      8
`define RSF_ST_BCAST        9
`define RSF_TXC_EXC_BIT     8
`define RSF_TXC_GO_BIT      9
`define RSF_RXI_FUNC_LSB    16

// Reset values: enabled, even parity, one stop bit, address 1.
`define RSF_CTRL_RESET      3'h3
`define RSF_SLAVE_RESET     8'h01
`define RSF_CLK_HZ          100000000
`define RSF_BAUD_DEFAULT    19200
`define RSF_DIV_RESET       (`RSF_CLK_HZ / `RSF_BAUD_DEFAULT)

// Character and silence timing, silences in tenths of a character.
`define RSF_BITS_PER_CHAR   11
`define RSF_GAP_FRAME_X10   35
`define RSF_GAP_ABORT_X10   15
`define RSF_GAP_FRAME_HALF  (((`RSF_GAP_FRAME_X10 * `RSF_BITS_PER_CHAR * 2) / 10) + 1)
`define RSF_GAP_ABORT_HALF  (((`RSF_GAP_ABORT_X10 * `RSF_BITS_PER_CHAR * 2) / 10) + 1)

// Frame contents.
`define RSF_CRC_INIT        16'hFFFF
`define RSF_CRC_POLY        16'hA001
`define RSF_EXC_MASK        8'h80
`define RSF_ADDR_BCAST      8'h00
`define RSF_ADDR_MAX        8'hF7
`define RSF_MIN_FRAME       9'h004
`define RSF_BUF_DEPTH       9'h100

`endif

// File: hdl/rsf_pkg.sv
package rsf_pkg;

  typedef enum logic [1:0] {RSF_PAR_NONE, RSF_PAR_EVEN, RSF_PAR_ODD, RSF_PAR_RSVD} rsf_parity_t;

  typedef enum logic [1:0] {RSF_RX_IDLE, RSF_RX_START, RSF_RX_BITS} rsf_rx_state_t;

  typedef enum logic [1:0] {RSF_TX_IDLE, RSF_TX_WAIT, RSF_TX_SEND} rsf_tx_state_t;

endpackage

// File: hdl/rsf_byte_ram.sv
`timescale 1ns/10ps
module rsf_byte_ram (
  input  wire logic       clk,
  input  wire logic       wr_en,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] raddr,
  output logic      [7:0] rdata
);

  logic [7:0] mem [0:255];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// File: hdl/rsf_framer.sv
// Functional notes
// - One start, eight data bits, LSB first.
// - Parity bit only when even/odd selected; the reserved setting also adds a parity bit, computed as even.
// - One stop with parity, two without.
// - Transmit only after 3.5 character silence.
// - 3.5 character silence ends every frame.
// - Silence timed from selected baud rate.
// - Gap over 1.5 chars flushes partial frame.
// - Early bytes join previous frame, CRC fails.
// - Incompletely ended frames raise error flag.
// - Always listen; first byte is address.
// - Address is one byte, 0 to 247.
// - Slave address 1..247, own frames processed.
// - Address 0 accepted, never answered.
// - Reply carries own slave address.
// - Function is one byte, 0x01..0xFF.
// - Normal reply echoes function byte.
// - Exception reply sets function MSB.
// - Exception reply carries cause code.
// - CRC-16 over whole frame, appended last.
// - CRC low byte first, high byte last.
// - Bad received CRC: drop, no reply.
// - Baud 2400..115200, default even, one stop.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
`include "rsf_consts.svh"
module rsf_framer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd,
  output logic             tx_en
);

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `RSF_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  function automatic logic par_bit(input logic [1:0] mode, input logic [7:0] data);
    return (^data) ^ (mode == rsf_pkg::RSF_PAR_ODD);
  endfunction

  // Register state.
  logic [2:0]  ctrl;
  logic [15:0] baud_div;
  logic [7:0]  slave_addr;
  logic [3:0]  status;
  logic [8:0]  rx_len;
  logic [7:0]  rx_func;
  logic        rx_bcast;
  logic [7:0]  tx_len;
  logic        tx_exc;
  logic [7:0]  exc_code;

  // APB decode.
  logic        apb_we;
  logic        apb_acc;
  logic        sel_ctrl;
  logic        sel_div;
  logic        sel_addr;
  logic        sel_stat;
  logic        sel_info;
  logic        sel_txc;
  logic        sel_exc;
  logic        sel_rxw;
  logic        sel_txw;
  logic        unmapped;
  logic [31:0] rd_mux;
  logic [7:0]  rx_ram_q;
  logic [7:0]  tx_ram_q;

  assign apb_acc  = psel & penable & ~pready;
  assign apb_we   = psel & penable & pready & pwrite;
  assign sel_ctrl = (paddr == `RSF_OFF_CTRL);
  assign sel_div  = (paddr == `RSF_OFF_BAUD_DIV);
  assign sel_addr = (paddr == `RSF_OFF_SLAVE_ADDR);
  assign sel_stat = (paddr == `RSF_OFF_STATUS);
  assign sel_info = (paddr == `RSF_OFF_RX_INFO);
  assign sel_txc  = (paddr == `RSF_OFF_TX_CTRL);
  assign sel_exc  = (paddr == `RSF_OFF_EXC_CODE);
  assign sel_rxw  = (paddr[11:10] == `RSF_WIN_RX) & (paddr[1:0] == 2'h0);
  assign sel_txw  = (paddr[11:10] == `RSF_WIN_TX) & (paddr[1:0] == 2'h0);
  assign unmapped = ~(sel_ctrl | sel_div | sel_addr | sel_stat | sel_info | sel_txc | sel_exc | sel_rxw | sel_txw);

  // Timing derived from the programmed bit period.
  logic [15:0] half_div;
  logic [15:0] hb_cnt;
  logic        hb_tick;
  logic [6:0]  sil_cnt;
  logic        sil_reset;
  logic        gap_abort;
  logic        gap_frame;

  // Receiver.
  rsf_pkg::rsf_rx_state_t rx_state;
  logic [15:0] rx_cnt;
  logic [3:0]  rx_bit;
  logic [9:0]  rx_shift;
  logic        rx_done;
  logic        rx_last;
  logic        rx_bad;
  logic [1:0]  par_mode;

  // Frame assembly.
  logic [8:0]  frm_len;
  logic [15:0] frm_crc;
  logic [7:0]  frm_addr;
  logic [7:0]  frm_func;
  logic        frm_bad;
  logic        frm_gap;
  logic        frm_ok_so_far;
  logic        frm_restart;
  logic [8:0]  frm_pos;
  logic        frm_end;
  logic        addr_ok;
  logic        ram_we;
  logic        ev_ready;
  logic        ev_incomplete;
  logic        ev_crc;
  logic        ev_char;

  // Transmitter.
  rsf_pkg::rsf_tx_state_t tx_state;
  logic [15:0] tx_cnt;
  logic [3:0]  tx_bit;
  logic [10:0] tx_shift;
  logic [8:0]  tx_idx;
  logic [8:0]  tx_total;
  logic [15:0] tx_crc;
  logic [7:0]  tx_byte;
  logic [7:0]  tx_raddr;
  logic        tx_go;
  logic        bit_end;
  logic        char_end;

  assign par_mode = ctrl[`RSF_CTRL_PAR_LSB +: 2];
  assign half_div = {1'b0, baud_div[15:1]};
  assign hb_tick  = (hb_cnt >= half_div - 16'h0001);

  assign sil_reset = ~rxd | (rx_state != rsf_pkg::RSF_RX_IDLE) | (tx_state == rsf_pkg::RSF_TX_SEND);
  assign gap_abort = (sil_cnt >= 7'(`RSF_GAP_ABORT_HALF));
  assign gap_frame = (sil_cnt >= 7'(`RSF_GAP_FRAME_HALF));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_cnt  <= 16'h0000;
      sil_cnt <= 7'h00;
    end else begin
      hb_cnt <= hb_tick ? 16'h0000 : hb_cnt + 16'h0001;
      if (sil_reset) begin
        sil_cnt <= 7'h00;
      end else if (hb_tick && !gap_frame) begin
        sil_cnt <= sil_cnt + 7'h01;
      end
    end
  end

  assign rx_last = (rx_state == rsf_pkg::RSF_RX_BITS) && (rx_cnt >= baud_div - 16'h0001) && (rx_bit == 4'h9);
  // parity or stop in bit nine
  assign rx_bad = ~rxd | ((par_mode == rsf_pkg::RSF_PAR_NONE) ? ~rx_shift[9] :
                          (rx_shift[9] != par_bit(par_mode, rx_shift[8:1])));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= rsf_pkg::RSF_RX_IDLE;
      rx_cnt   <= 16'h0000;
      rx_bit   <= 4'h0;
      rx_shift <= 10'h000;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      rx_cnt  <= rx_cnt + 16'h0001;
      case (rx_state)
        rsf_pkg::RSF_RX_IDLE: begin
          rx_cnt <= 16'h0000;
          if (!rxd) begin
            rx_state <= rsf_pkg::RSF_RX_START;
          end
        end
        rsf_pkg::RSF_RX_START: begin
          if (rx_cnt >= half_div - 16'h0001) begin
            rx_cnt   <= 16'h0000;
            rx_bit   <= 4'h0;
            rx_state <= rxd ? rsf_pkg::RSF_RX_IDLE : rsf_pkg::RSF_RX_BITS;
          end
        end
        rsf_pkg::RSF_RX_BITS: begin
          if (rx_cnt >= baud_div - 16'h0001) begin
            rx_cnt   <= 16'h0000;
            rx_bit   <= rx_bit + 4'h1;
            // The final stop is only checked, so the data byte stays in rx_shift[8:1] for the store.
            if (rx_bit == 4'h9) begin
              rx_done  <= 1'b1;
              rx_state <= rsf_pkg::RSF_RX_IDLE;
            end else begin
              rx_shift <= {rxd, rx_shift[9:1]};
            end
          end
        end
        default: rx_state <= rsf_pkg::RSF_RX_IDLE;
      endcase
    end
  end

  // The character error is folded into the frame at the same edge as the byte.
  logic rx_bad_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bad_q <= 1'b0;
    end else if (rx_last) begin
      rx_bad_q <= rx_bad;
    end
  end

  // A gap counts as harmless only if what came before already closes with a good CRC.
  assign frm_ok_so_far = (frm_len >= `RSF_MIN_FRAME) && (frm_crc == 16'h0000);
  assign frm_restart   = (frm_len == 9'h000) || (frm_gap && !frm_ok_so_far);
  assign frm_pos       = frm_restart ? 9'h000 : frm_len;
  assign ram_we        = rx_done && (frm_pos < `RSF_BUF_DEPTH);
  assign frm_end       = gap_frame && (frm_len != 9'h000);
  assign addr_ok = (frm_addr <= `RSF_ADDR_MAX) &&
                   ((frm_addr == slave_addr) || (frm_addr == `RSF_ADDR_BCAST));
  assign ev_incomplete = (rx_done && frm_gap && !frm_ok_so_far && frm_len != 9'h000) |
                         (frm_end && frm_len < `RSF_MIN_FRAME);
  assign ev_crc   = frm_end && (frm_len >= `RSF_MIN_FRAME) && (frm_crc != 16'h0000);
  assign ev_char  = frm_end && frm_ok_so_far && frm_bad;
  assign ev_ready = frm_end && frm_ok_so_far && !frm_bad && addr_ok &&
                    (frm_func != 8'h00) && ctrl[`RSF_CTRL_EN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_len  <= 9'h000;
      frm_crc  <= `RSF_CRC_INIT;
      frm_addr <= 8'h00;
      frm_func <= 8'h00;
      frm_bad  <= 1'b0;
      frm_gap  <= 1'b0;
    end else if (rx_done) begin
      frm_len  <= (frm_pos < `RSF_BUF_DEPTH) ? frm_pos + 9'h001 : frm_pos;
      frm_crc  <= crc_step(frm_restart ? `RSF_CRC_INIT : frm_crc, rx_shift[8:1]);
      frm_bad  <= (frm_restart ? 1'b0 : frm_bad) | rx_bad_q | (frm_pos >= `RSF_BUF_DEPTH);
      frm_gap  <= 1'b0;
      if (frm_pos == 9'h000) begin
        frm_addr <= rx_shift[8:1];
      end
      if (frm_pos == 9'h001) begin
        frm_func <= rx_shift[8:1];
      end
    end else if (frm_end) begin
      frm_len <= 9'h000;
      frm_gap <= 1'b0;
    end else if (gap_abort && frm_len != 9'h000) begin
      frm_gap <= 1'b1;
    end
  end

  rsf_byte_ram u_rx_ram (
    .clk   (pclk),
    .wr_en (ram_we),
    .waddr (frm_pos[7:0]),
    .wdata (rx_shift[8:1]),
    .raddr (paddr[9:2]),
    .rdata (rx_ram_q)
  );

  // Transmit path.
  assign tx_go    = apb_we && sel_txc && pwdata[`RSF_TXC_GO_BIT] && (tx_state == rsf_pkg::RSF_TX_IDLE) && !rx_bcast;
  assign tx_total = tx_exc ? 9'h005 : {1'b0, tx_len} + 9'h004;
  // The read address runs one byte ahead, so the buffer output is settled when the next character loads.
  assign tx_raddr = 8'(tx_idx - 9'h001);
  assign bit_end  = (tx_cnt >= baud_div - 16'h0001);
  assign char_end = bit_end && (tx_bit == 4'(`RSF_BITS_PER_CHAR - 1));

  assign tx_byte = (tx_idx == 9'h000)           ? slave_addr :
                   (tx_idx == 9'h001)           ? (tx_exc ? (rx_func | `RSF_EXC_MASK) : rx_func) :
                   (tx_idx == tx_total - 9'h002) ? tx_crc[7:0] :
                   (tx_idx == tx_total - 9'h001) ? tx_crc[15:8] :
                   tx_exc                       ? exc_code : tx_ram_q;

  rsf_byte_ram u_tx_ram (
    .clk   (pclk),
    .wr_en (apb_we && sel_txw),
    .waddr (paddr[9:2]),
    .wdata (pwdata[7:0]),
    .raddr (tx_raddr),
    .rdata (tx_ram_q)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= rsf_pkg::RSF_TX_IDLE;
      tx_cnt   <= 16'h0000;
      tx_bit   <= 4'h0;
      tx_shift <= 11'h7FF;
      tx_idx   <= 9'h000;
      tx_crc   <= `RSF_CRC_INIT;
      txd      <= 1'b1;
      tx_en    <= 1'b0;
    end else begin
      case (tx_state)
        rsf_pkg::RSF_TX_IDLE: begin
          tx_idx <= 9'h000;
          tx_crc <= `RSF_CRC_INIT;
          if (tx_go) begin
            tx_state <= rsf_pkg::RSF_TX_WAIT;
          end
        end
        rsf_pkg::RSF_TX_WAIT: begin
          // leading silence before the first character
          // Only the first character waits; later ones follow at once so the reply stays one frame.
          if (gap_frame || tx_idx != 9'h000) begin
            tx_state <= rsf_pkg::RSF_TX_SEND;
            tx_cnt   <= 16'h0000;
            tx_bit   <= 4'h0;
            tx_shift <= {1'b1, (par_mode == rsf_pkg::RSF_PAR_NONE) ? 1'b1 : par_bit(par_mode, tx_byte),
                         tx_byte, 1'b0};
            txd      <= 1'b0;
            tx_en    <= 1'b1;
          end
        end
        rsf_pkg::RSF_TX_SEND: begin
          tx_cnt <= bit_end ? 16'h0000 : tx_cnt + 16'h0001;
          if (char_end) begin
            // CRC over every byte ahead of it
            if (tx_idx < tx_total - 9'h002) begin
              tx_crc <= crc_step(tx_crc, tx_shift[8:1]);
            end
            tx_idx <= tx_idx + 9'h001;
            if (tx_idx == tx_total - 9'h001) begin
              tx_state <= rsf_pkg::RSF_TX_IDLE;
              tx_en    <= 1'b0;
              txd      <= 1'b1;
            end else begin
              tx_state <= rsf_pkg::RSF_TX_WAIT;
            end
          end else if (bit_end) begin
            tx_bit <= tx_bit + 4'h1;
            txd    <= tx_shift[tx_bit + 4'h1];
          end
        end
        default: tx_state <= rsf_pkg::RSF_TX_IDLE;
      endcase
    end
  end

  // Registers. Hardware events win over a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= `RSF_CTRL_RESET;
      baud_div   <= 16'(`RSF_DIV_RESET);
      slave_addr <= `RSF_SLAVE_RESET;
      status     <= 4'h0;
      rx_len     <= 9'h000;
      rx_func    <= 8'h00;
      rx_bcast   <= 1'b0;
      tx_len     <= 8'h00;
      tx_exc     <= 1'b0;
      exc_code   <= 8'h00;
    end else begin
      if (apb_we && sel_ctrl) begin
        ctrl <= pwdata[2:0];
      end
      if (apb_we && sel_div) begin
        baud_div <= pwdata[15:0];
      end
      if (apb_we && sel_addr) begin
        slave_addr <= pwdata[7:0];
      end
      if (apb_we && sel_txc && tx_state == rsf_pkg::RSF_TX_IDLE) begin
        tx_len <= pwdata[7:0];
        tx_exc <= pwdata[`RSF_TXC_EXC_BIT];
      end
      if (apb_we && sel_exc) begin
        exc_code <= pwdata[7:0];
      end
      status <= (status & ~((apb_we && sel_stat) ? pwdata[3:0] : 4'h0)) |
                {ev_char, ev_crc, ev_incomplete, ev_ready};
      if (ev_ready) begin
        rx_len   <= frm_len;
        rx_func  <= frm_func;
        rx_bcast <= (frm_addr == `RSF_ADDR_BCAST);
      end
    end
  end

  // Read mux; the buffer window reads the memory's registered output.
  assign rd_mux = sel_ctrl ? {29'h0, ctrl} :
                  sel_div  ? {16'h0, baud_div} :
                  sel_addr ? {24'h0, slave_addr} :
                  sel_stat ? {22'h0, rx_bcast, (tx_state != rsf_pkg::RSF_TX_IDLE), 4'h0, status} :
                  sel_info ? {8'h0, rx_func, 7'h0, rx_len} :
                  sel_txc  ? {23'h0, tx_exc, tx_len} :
                  sel_exc  ? {24'h0, exc_code} :
                  sel_rxw  ? {24'h0, rx_ram_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= apb_acc;
      pslverr <= apb_acc & unmapped;
      prdata  <= (apb_acc && !pwrite) ? rd_mux : 32'h0;
    end
  end

endmodule

// File: bench/rsf_framer_props.sv
`timescale 1ns/10ps
`include "rsf_consts.svh"
module rsf_framer_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        tx_en
);
  logic [15:0] div;
  logic [31:0] quiet;
  logic [31:0] low_run;
  logic [31:0] hi_run;
  wire         div_wr = psel && penable && pready && pwrite && !pslverr && paddr == `RSF_OFF_BAUD_DIV;

  // The bit time is tracked from bus writes, so the line checks follow the live rate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div     <= 16'(`RSF_DIV_RESET);
      quiet   <= 32'h0;
      low_run <= 32'h0;
      hi_run  <= 32'h0;
    end else begin
      div     <= div_wr ? pwdata[15:0] : div;
      quiet   <= (rxd && txd && !tx_en) ? quiet + 32'h1 : 32'h0;
      low_run <= txd ? 32'h0 : low_run + 32'h1;
      hi_run  <= (tx_en && txd) ? hi_run + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && !pready;
  endsequence

  a_ready_one_wait: assert property (s_setup ##1 s_access |=> pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr without pready or with data");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  a_line_idle_high: assert property (!tx_en |-> txd)
    else $error("txd low while driver off");
  a_tx_start_bit: assert property ($rose(tx_en) |-> !txd)
    else $error("frame does not open with start bit");
  a_bit_whole: assert property ($rose(txd) && low_run != 32'h0 |-> (low_run % div) == 32'h0)
    else $error("txd low run not whole bits");
  a_tx_quiet_first: assert property ($rose(tx_en) |-> 2 * quiet >= 77 * div)
    else $error("reply started without line silence");
  a_tx_stop_end: assert property ($fell(tx_en) |-> hi_run >= 32'(div))
    else $error("driver released before stop bit ended");
  a_tx_no_gap: assert property (tx_en |-> hi_run <= 32'(11 * div))
    else $error("idle gap inside a reply frame");
endmodule

bind rsf_framer rsf_framer_props u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd(rxd), .txd(txd), .tx_en(tx_en));

// File: bench/rsf_rtu_master.sv
`timescale 1ns/10ps
module rsf_rtu_master #(
  parameter int BIT_CYC = 16
) (
  input  wire logic pclk,
  output logic      rxd,
  input  wire logic txd,
  input  wire logic tx_en
);
  logic [7:0] got[$];
  logic [7:0] rx_byte;

  // The biased line rests high between frames.
  initial rxd = 1'b1;

  task automatic send_byte(input logic [7:0] b, input rsf_pkg::rsf_parity_t p);
    logic [10:0] sh;
    sh = (p == rsf_pkg::RSF_PAR_NONE) ? {2'b11, b, 1'b0} : {1'b1, (p == rsf_pkg::RSF_PAR_ODD) ? ~^b : ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= sh[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
  endtask

  task automatic send_frame(input logic [7:0] q[$], input rsf_pkg::rsf_parity_t p);
    foreach (q[i]) send_byte(q[i], p);
  endtask

  // Skips parity and stop bits after each byte, so a low parity bit is not taken for a start.
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge pclk);
    if (tx_en === 1'b1 && txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge pclk);
        rx_byte[i] = txd;
      end
      got.push_back(rx_byte);
      repeat (2 * BIT_CYC) @(posedge pclk);
    end
  end
endmodule

// File: bench/tb.sv
`timescale 1ns/10ps
`include "rsf_consts.svh"
module tb;
  localparam int BITC = 16;
  localparam int CHAR = 11 * BITC;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, tx_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail, n_compared, cyc;

  rsf_framer u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .tx_en(tx_en));
  rsf_rtu_master #(.BIT_CYC(BITC)) u_master (.pclk(pclk), .rxd(rxd), .txd(txd), .tx_en(tx_en));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task tally_and_finish;
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd & mask, exp);
  endtask

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction

  task automatic seal(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask

  task automatic rx_frame(input string name, input logic [7:0] q[$], input rsf_pkg::rsf_parity_t p,
                          input logic [31:0] exp);
    u_master.send_frame(q, p);
    repeat (5 * CHAR) @(posedge pclk);
    rchk(name, `RSF_OFF_STATUS, 32'h30F, exp);
    apb(1'b1, `RSF_OFF_STATUS, 32'h0000_000F);
  endtask

  task automatic tx_reply(input logic [31:0] ctrl, input logic [7:0] exp[$]);
    u_master.got.delete();
    apb(1'b1, `RSF_OFF_TX_CTRL, ctrl);
    for (int i = 0; i < 2000; i++) begin
      apb(1'b0, `RSF_OFF_STATUS, 32'h0);
      if (rd[8] === 1'b0) break;
    end
    repeat (5 * CHAR) @(posedge pclk);
    check("reply length", 32'(u_master.got.size()), 32'(exp.size()));
    foreach (exp[i]) check("reply byte", {24'h0, u_master.got[i]}, {24'h0, exp[i]});
  endtask

  task automatic t_regs;
    rchk("ctrl reset", `RSF_OFF_CTRL, 32'h7, 32'h3);
    rchk("baud reset", `RSF_OFF_BAUD_DIV, 32'hFFFF, 32'h1458);
    rchk("slave reset", `RSF_OFF_SLAVE_ADDR, 32'hFF, 32'h01);
    apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
    check("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, `RSF_OFF_BAUD_DIV, 32'(BITC));
    apb(1'b1, `RSF_OFF_SLAVE_ADDR, 32'h11);
    rchk("slave addr", `RSF_OFF_SLAVE_ADDR, 32'hFF, 32'h11);
    repeat (4 * CHAR) @(posedge pclk);
  endtask

  task automatic t_reply;
    logic [7:0] q[$];
    q = '{8'h11, 8'h03, 8'h0A, 8'hB5};
    seal(q);
    rx_frame("own frame", q, rsf_pkg::RSF_PAR_EVEN, 32'h001);
    rchk("rx info", `RSF_OFF_RX_INFO, 32'h00FF_01FF, 32'h0003_0006);
    rchk("rx addr byte", 12'h400, 32'hFF, 32'h11);
    apb(1'b1, 12'h800, 32'h5A);
    apb(1'b1, 12'h804, 32'hC3);
    q = '{8'h11, 8'h03, 8'h5A, 8'hC3};
    seal(q);
    tx_reply(32'h202, q);
    apb(1'b1, `RSF_OFF_EXC_CODE, 32'h02);
    q = '{8'h11, 8'h83, 8'h02};
    seal(q);
    tx_reply(32'h300, q);
  endtask

  task automatic t_reject;
    logic [7:0]  q[$];
    logic [15:0] hdr[3];
    hdr = '{16'h1203, 16'hF803, 16'h1100};
    foreach (hdr[i]) begin
      q = '{hdr[i][15:8], hdr[i][7:0], 8'h0A};
      seal(q);
      rx_frame("dropped frame", q, rsf_pkg::RSF_PAR_EVEN, 32'h000);
    end
    q[4] = q[4] ^ 8'hFF;
    q[0] = 8'h11;
    rx_frame("bad crc", q, rsf_pkg::RSF_PAR_EVEN, 32'h004);
    q = '{8'h11, 8'h03, 8'h0A};
    seal(q);
    u_master.send_frame(q, rsf_pkg::RSF_PAR_EVEN);
    repeat (2 * CHAR) @(posedge pclk);
    rx_frame("appended byte", '{8'h11}, rsf_pkg::RSF_PAR_EVEN, 32'h004);
  endtask

  task automatic t_bcast_gap;
    logic [7:0] q[$];
    logic [7:0] none[$];
    q = '{8'h00, 8'h06, 8'h0A, 8'hB5};
    seal(q);
    rx_frame("broadcast", q, rsf_pkg::RSF_PAR_EVEN, 32'h201);
    tx_reply(32'h202, none);
    u_master.send_frame('{8'h11, 8'h03}, rsf_pkg::RSF_PAR_EVEN);
    repeat (2 * CHAR) @(posedge pclk);
    q = '{8'h11, 8'h03, 8'h0A, 8'hB5};
    seal(q);
    rx_frame("flush then frame", q, rsf_pkg::RSF_PAR_EVEN, 32'h003);
    rx_frame("short frame", '{8'h11, 8'h03}, rsf_pkg::RSF_PAR_EVEN, 32'h002);
  endtask

  task automatic t_parity;
    logic [7:0]           q[$];
    rsf_pkg::rsf_parity_t pm[3];
    pm = '{rsf_pkg::RSF_PAR_NONE, rsf_pkg::RSF_PAR_ODD, rsf_pkg::RSF_PAR_EVEN};
    q = '{8'h11, 8'h04, 8'h80};
    seal(q);
    foreach (pm[i]) begin
      apb(1'b1, `RSF_OFF_CTRL, {29'h0, pm[i], 1'b1});
      rx_frame("parity mode", q, pm[i], 32'h001);
    end
    rx_frame("parity error", q, rsf_pkg::RSF_PAR_ODD, 32'h008);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_reply;
    t_reject;
    t_bcast_gap;
    t_parity;
    tally_and_finish;
  end
endmodule
